// file: modsel_pkg.sv
// Purpose: Constants for the internal module select decoder
// Assumes: 32-bit byte addresses on both internal buses
// Notes:   Memory block sizes are powers of two, given as log2 of bytes
package modsel_pkg;

	localparam int unsigned ADDR_W = 32;

	// --------------------------------------------------------------
	// Placement field encodings
	// --------------------------------------------------------------
	localparam logic [1:0] PLACE_LOW_START  = 2'h0;
	localparam logic [1:0] PLACE_LOW_END    = 2'h1;
	localparam logic [1:0] PLACE_HIGH_START = 2'h2;
	localparam logic [1:0] PLACE_HIGH_END   = 2'h3;

	localparam logic [31:0] LOW_START_ADDR  = 32'h0000_0000;
	localparam logic [31:0] LOW_END_ADDR    = 32'h000F_FFFF;
	localparam logic [31:0] HIGH_START_ADDR = 32'hFFF0_0000;
	localparam logic [31:0] HIGH_END_ADDR   = 32'hFFFF_FFFF;

	// --------------------------------------------------------------
	// Control register and peripheral bridge window
	// --------------------------------------------------------------
	localparam logic [31:0] CTRL_WIN_BASE = 32'h8000_0000;
	localparam logic [31:0] CTRL_WIN_LAST = 32'h8007_FFFF;
	localparam logic [31:0] CTRL_REG_BASE = 32'h8007_F000;
	localparam logic [31:0] CTRL_REG_SIZE = 32'h0000_1000;
	localparam int unsigned BRIDGE_N_MIN  = 13;
	localparam int unsigned BRIDGE_N_MAX  = 19;

	// Destination codes for one access
	typedef enum logic [2:0] {
		DEST_EXTERNAL = 3'h0,
		DEST_IMEM     = 3'h1,
		DEST_LMEM     = 3'h3,
		DEST_CTRL     = 3'h2,
		DEST_BRIDGE   = 3'h6,
		DEST_ERROR    = 3'h7
	} dest_t;

endpackage

// file: module_select_decode.sv
// Purpose: Module select decode for the instruction and load/store buses
// Assumes: Placement fields and enables are held stable by configuration logic
// Notes:   Selects are combinational; only the error strobes are registered
//          Overlap is judged by equal placement codes, exact for the default sizes
//          A bridge exponent outside its legal span is clamped, not refused
//          A fetch into the bridge range is refused like one into the registers
//
// Operation
// - One shared map serves both buses
// - Module control registers stay at fixed address
// - Load/store masters may reach instruction-bus slaves
// - Instruction fetch may run from load/store RAM
// - One select block per memory category
// - Codes 00 and 10 fix block start
// - Codes 01 and 11 fix block end
// - Other boundary follows the block size
// - Each bus field places its own block
// - Unimplemented hole in block raises machine check
// - 0x80000000-0x8007FFFF is control and bridge window
// - Top 4K of window selects control registers
// - Bridge abuts registers, size 2^n minus 4K
// - Control and bridge selects cannot be disabled
// - Fetch to control window gives transfer error
// - Absent memory access goes to external bus
// - Present overlapping memories both go external
`timescale 1ns/1ps
module module_select_decode
	import modsel_pkg::*;
#(
	parameter int unsigned IMEM_LOG2  = 18,
	parameter int unsigned LMEM_LOG2  = 16,
	parameter int unsigned IMEM_IMPL  = 32'h0003_0000,
	parameter int unsigned LMEM_IMPL  = 32'h0000_8000,
	parameter int unsigned BRIDGE_N   = 19
)
(
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic [1:0]          instr_mem_placement,
	input  wire logic [1:0]          ldst_mem_placement,
	input  wire logic                instr_mem_enable,
	input  wire logic                ldst_mem_enable,
	input  wire logic                ldst_cross_enable,
	input  wire logic                instr_mem_present,
	input  wire logic                ldst_mem_present,
	input  wire logic                ib_valid,
	input  wire logic [ADDR_W-1:0]   ib_addr,
	input  wire logic                lb_valid,
	input  wire logic [ADDR_W-1:0]   lb_addr,
	output logic                     ib_sel_imem,
	output logic                     ib_sel_lmem,
	output logic                     ib_sel_external,
	output logic                     ib_machine_check,
	output logic                     ib_transfer_error_ack,
	output logic                     lb_sel_imem,
	output logic                     lb_sel_lmem,
	output logic                     lb_sel_ctrl,
	output logic                     lb_sel_bridge,
	output logic                     lb_sel_external,
	output logic                     lb_machine_check,
	output logic                     ib_error_q_out,
	output logic                     lb_error_q_out
);

	// --------------------------------------------------------------
	// Block placement
	// --------------------------------------------------------------
	// Base of a block from its placement code and size
	function automatic logic [31:0] block_base(input logic [1:0] code, input int unsigned lg);
		logic [31:0] size;
		size = 32'h1 << lg;
		unique case (code)
			PLACE_LOW_START:  block_base = LOW_START_ADDR;
			PLACE_LOW_END:    block_base = LOW_END_ADDR - size + 32'h1;
			PLACE_HIGH_START: block_base = HIGH_START_ADDR;
			PLACE_HIGH_END:   block_base = HIGH_END_ADDR - size + 32'h1;
		endcase
	endfunction

	// Block hit: address high bits match the aligned base
	function automatic logic in_block(input logic [31:0] a, input logic [31:0] b,
		input int unsigned lg);
		logic [31:0] mask;
		mask = ~((32'h1 << lg) - 32'h1);
		in_block = (a & mask) == (b & mask);
	endfunction

	logic [31:0] imem_base;
	logic [31:0] lmem_base;
	logic        overlap;
	logic        imem_live;
	logic        lmem_live;

	always_comb
	begin
		imem_base = block_base(instr_mem_placement, IMEM_LOG2);
		lmem_base = block_base(ldst_mem_placement, LMEM_LOG2);
		// Code equality stands for address overlap; bigger blocks would need a range test
		overlap   = instr_mem_placement == ldst_mem_placement;
		// Both present and overlapping is a mapping error: neither responds
		imem_live = instr_mem_present && instr_mem_enable
			&& !(overlap && ldst_mem_present);
		lmem_live = ldst_mem_present && ldst_mem_enable
			&& !(overlap && instr_mem_present);
	end

	// --------------------------------------------------------------
	// Shared decode, one copy per bus
	// --------------------------------------------------------------
	// An out-of-range bridge exponent is pulled into the legal span, so
	// the bridge never spills out of the window
	localparam int unsigned BRIDGE_LOG2 = (BRIDGE_N < BRIDGE_N_MIN) ? BRIDGE_N_MIN
		: (BRIDGE_N > BRIDGE_N_MAX) ? BRIDGE_N_MAX : BRIDGE_N;
	localparam logic [31:0] BRIDGE_BASE = CTRL_REG_BASE
		- ((32'h1 << BRIDGE_LOG2) - CTRL_REG_SIZE);

	localparam int unsigned N_BUS  = 2;
	localparam int unsigned BUS_IB = 0;
	localparam int unsigned BUS_LB = 1;

	logic [ADDR_W-1:0] bus_addr [N_BUS];
	dest_t             ib_dest;
	dest_t             lb_dest;
	logic              ib_ctrl_hit;

	always_comb
	begin
		bus_addr[BUS_IB] = ib_addr;
		bus_addr[BUS_LB] = lb_addr;
	end

	// Array window control registers are not in the block; they live in the
	// fixed register page, so relocating the array never moves them.
	for (genvar b = 0; b < N_BUS; b++)
	begin : g_bus
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] off_imem;
		logic [ADDR_W-1:0] off_lmem;
		logic              hit_ctrl;
		logic              hit_bridge;
		logic              hit_imem;
		logic              hit_lmem;
		dest_t             dest;

		always_comb
		begin
			addr       = bus_addr[b];
			off_imem   = addr - imem_base;
			off_lmem   = addr - lmem_base;
			hit_ctrl   = addr >= CTRL_REG_BASE && addr <= CTRL_WIN_LAST;
			hit_bridge = addr >= BRIDGE_BASE && addr < CTRL_REG_BASE;
			hit_imem   = in_block(addr, imem_base, IMEM_LOG2) && imem_live;
			hit_lmem   = in_block(addr, lmem_base, LMEM_LOG2) && lmem_live;
			// Fixed window outranks any array placed over it
			dest = DEST_EXTERNAL;
			if (hit_ctrl)
				dest = DEST_CTRL;
			else if (hit_bridge)
				dest = DEST_BRIDGE;
			else if (hit_imem)
				dest = (off_imem < IMEM_IMPL) ? DEST_IMEM : DEST_ERROR;
			else if (hit_lmem)
				dest = (off_lmem < LMEM_IMPL) ? DEST_LMEM : DEST_ERROR;
		end
	end

	// --------------------------------------------------------------
	// Outcome per bus
	// --------------------------------------------------------------
	// Exactly one outcome per valid cycle on each bus
	always_comb
	begin
		ib_dest = g_bus[BUS_IB].dest;
		lb_dest = g_bus[BUS_LB].dest;
		ib_ctrl_hit = ib_dest == DEST_CTRL || ib_dest == DEST_BRIDGE;
		// Instruction side
		ib_sel_imem      = ib_valid && ib_dest == DEST_IMEM;
		ib_sel_lmem      = ib_valid && ib_dest == DEST_LMEM;
		ib_sel_external  = ib_valid && ib_dest == DEST_EXTERNAL;
		ib_machine_check = ib_valid && ib_dest == DEST_ERROR;
		ib_transfer_error_ack = ib_valid && ib_ctrl_hit;
		// Load/store side; cross access to the instruction array may be sent off chip
		lb_sel_imem      = lb_valid && lb_dest == DEST_IMEM && ldst_cross_enable;
		lb_sel_lmem      = lb_valid && lb_dest == DEST_LMEM;
		lb_sel_ctrl      = lb_valid && lb_dest == DEST_CTRL;
		lb_sel_bridge    = lb_valid && lb_dest == DEST_BRIDGE;
		lb_sel_external  = lb_valid && (lb_dest == DEST_EXTERNAL
			|| (lb_dest == DEST_IMEM && !ldst_cross_enable));
		lb_machine_check = lb_valid && lb_dest == DEST_ERROR;
	end

	// --------------------------------------------------------------
	// Registered error record
	// --------------------------------------------------------------
	typedef struct packed {
		logic ib_err;
		logic lb_err;
	} state_t;

	state_t s_q;
	state_t s_d;

	always_comb
	begin
		// One pulse per error cycle; back-to-back errors stay high
		s_d.ib_err = ib_machine_check || ib_transfer_error_ack;
		s_d.lb_err = lb_machine_check;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign ib_error_q_out = s_q.ib_err;
	assign lb_error_q_out = s_q.lb_err;

endmodule

// file: modsel_sva.sv
// Purpose: Port checks for the module select decoder
// Assumes: Default sizes, instruction block 256K, bridge n of 19
// Notes:   Selects are combinational, so most checks are same-cycle
`timescale 1ns/1ps
module modsel_sva
	import modsel_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic [1:0]        instr_mem_placement,
	input wire logic [1:0]        ldst_mem_placement,
	input wire logic              instr_mem_present,
	input wire logic              ldst_mem_present,
	input wire logic              ib_valid,
	input wire logic [ADDR_W-1:0] ib_addr,
	input wire logic              lb_valid,
	input wire logic [ADDR_W-1:0] lb_addr,
	input wire logic              ib_sel_imem,
	input wire logic              ib_sel_lmem,
	input wire logic              ib_sel_external,
	input wire logic              ib_machine_check,
	input wire logic              ib_transfer_error_ack,
	input wire logic              lb_sel_ctrl,
	input wire logic              lb_sel_bridge,
	input wire logic              ib_error_q_out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	ctrl_sel_a: assert property (lb_valid && lb_addr[31:12] == 20'h8007F |-> lb_sel_ctrl)
		else $error("ctrl select missing");
	bridge_sel_a: assert property (lb_valid && lb_addr[31:12] == 20'h8000E |-> lb_sel_bridge)
		else $error("bridge select missing");
	fetch_err_a: assert property (
		ib_valid && ib_addr[31:19] == 13'h1000
		|-> ib_transfer_error_ack && !ib_sel_external)
		else $error("fetch into window not refused");
	err_pulse_a: assert property (
		ib_valid && (ib_machine_check || ib_transfer_error_ack) |=> ib_error_q_out)
		else $error("error strobe missing");
	no_err_a: assert property (!ib_valid |=> !ib_error_q_out)
		else $error("error strobe without cause");
	ib_onehot_a: assert property (
		ib_valid |-> $onehot({ib_sel_imem, ib_sel_lmem,
		ib_sel_external, ib_machine_check, ib_transfer_error_ack}))
		else $error("instruction bus outcome not unique");
	overlap_ext_a: assert property (
		ib_valid && instr_mem_present && ldst_mem_present
		&& instr_mem_placement == ldst_mem_placement |-> !ib_sel_imem && !ib_sel_lmem)
		else $error("overlap served internally");
	low_start_a: assert property (
		ib_sel_imem && instr_mem_placement == 2'h0 |-> ib_addr[31:18] == 14'h0)
		else $error("low block selected out of range");
	cov_ctrl_c: cover property (lb_valid && lb_sel_ctrl);
	cov_err_c: cover property (ib_transfer_error_ack ##1 ib_error_q_out);
	cov_mc_c: cover property (ib_machine_check);
endmodule

// file: bus_masters.sv
// Purpose: Instruction and load/store bus masters facing the decoder
// Assumes: One access a cycle, launched on the rising edge
// Notes:   Idle address is the inverse of the last, so stale values never look valid
`timescale 1ns/1ps
module bus_masters
	import modsel_pkg::*;
(
	input wire logic               ref_clk,
	output logic                   ib_valid = 1'h0,
	output logic [ADDR_W-1:0]      ib_addr = 32'h0,
	output logic                   lb_valid = 1'h0,
	output logic [ADDR_W-1:0]      lb_addr = 32'h0
);
	task automatic go(input int ib, input logic [31:0] a);
		@(posedge ref_clk);
		ib_valid <= ib != 0;
		lb_valid <= ib == 0;
		ib_addr <= (ib != 0) ? a : ~ib_addr;
		lb_addr <= (ib != 0) ? ~lb_addr : a;
		#2;
	endtask
endmodule

// file: internal_module_select_decode_tb.sv
// Purpose: Self-checking bench for the module select decoder
// Assumes: Default parameters of the decoder
// Notes:   Outputs judged 2 ns after each launch edge
`timescale 1ns/1ps
module internal_module_select_decode_tb;
	import modsel_pkg::*;
	logic ref_clk = 1'h0, rst_n = 1'h0, ie, le, cx, ip, lp;
	logic [1:0] ipl, lpl;
	logic ib_valid, lb_valid, i1, i2, i3, i4, i5, l1, l2, l3, l4, l5, l6, ieq, leq;
	logic [31:0] ib_addr, lb_addr;
	int fail_count = 0, n_tests = 0;
	wire [5:0] ibv = {1'h0, i1, i2, i3, i4, i5};
	wire [5:0] lbv = {l1, l2, l3, l4, l5, l6};
	always #10 ref_clk = ~ref_clk;
	bus_masters u_bus_masters (.ref_clk(ref_clk), .ib_valid(ib_valid), .ib_addr(ib_addr),
		.lb_valid(lb_valid), .lb_addr(lb_addr));
	module_select_decode u_module_select_decode (.ref_clk(ref_clk), .rst_n(rst_n),
		.instr_mem_placement(ipl), .ldst_mem_placement(lpl), .instr_mem_enable(ie),
		.ldst_mem_enable(le), .ldst_cross_enable(cx), .instr_mem_present(ip),
		.ldst_mem_present(lp), .ib_valid(ib_valid), .ib_addr(ib_addr), .lb_valid(lb_valid),
		.lb_addr(lb_addr), .ib_sel_imem(i1), .ib_sel_lmem(i2), .ib_sel_external(i3),
		.ib_machine_check(i4), .ib_transfer_error_ack(i5), .lb_sel_imem(l1), .lb_sel_lmem(l2),
		.lb_sel_ctrl(l3), .lb_sel_bridge(l4), .lb_sel_external(l5), .lb_machine_check(l6),
		.ib_error_q_out(ieq), .lb_error_q_out(leq));
	task automatic chk(input logic [5:0] s, input logic [5:0] e);
		n_tests++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error select expected %h seen %h", e, s);
		end
	endtask
	task automatic cfg(input int a, input int b, input logic [4:0] f);
		@(posedge ref_clk);
		ipl <= 2'(a);
		lpl <= 2'(b);
		{ie, le, cx, ip, lp} <= f;
	endtask
	function automatic logic [31:0] base(input int p, input int lg);
		return p == 0 ? 32'h0 : p == 2 ? 32'hFFF0_0000 :
			(p == 1 ? 32'h0010_0000 : 32'h0) - (32'h1 << lg);
	endfunction
	task automatic t_place;
		for (int p = 0; p < 4; p++)
		begin
			cfg(p, p ^ 1, 5'h1F);
			u_bus_masters.go(1, base(p, 18) + 32'h2_FFFC); chk(ibv, 6'h10);
			u_bus_masters.go(1, base(p ^ 1, 16)); chk(ibv, 6'h08);
			u_bus_masters.go(1, base(p, 18) + 32'h3_0000); chk(ibv, 6'h02);
			u_bus_masters.go(0, base(p, 18) + 32'h4); chk(lbv, 6'h20);
			u_bus_masters.go(0, base(p ^ 1, 16) + 32'h7FFC); chk(lbv, 6'h10);
			u_bus_masters.go(0, base(p ^ 1, 16) + 32'h8000); chk(lbv, 6'h01);
			u_bus_masters.go(0, 32'h8007_F000); chk({lbv[5:1], leq}, 6'h09);
		end
		$display("placement test done");
	endtask
	task automatic t_window;
		cfg(0, 1, 5'h03);
		u_bus_masters.go(0, 32'h8007_F000); chk(lbv, 6'h08);
		u_bus_masters.go(0, 32'h8007_EFFF); chk(lbv, 6'h04);
		u_bus_masters.go(0, 32'h8000_0000); chk(lbv, 6'h04);
		u_bus_masters.go(1, 32'h8007_F010); chk(ibv, 6'h01);
		u_bus_masters.go(1, 32'h0000_0100); chk({ibv[5:1], ieq}, 6'h05);
		$display("window test done");
	endtask
	task automatic t_conflict;
		cfg(0, 1, 5'h1B);
		u_bus_masters.go(0, 32'h100); chk(lbv, 6'h02);
		cfg(0, 0, 5'h1F);
		u_bus_masters.go(1, 32'h100); chk(ibv, 6'h04);
		cfg(0, 0, 5'h1D);
		u_bus_masters.go(1, 32'h100); chk(ibv, 6'h08);
		cfg(0, 1, 5'h1D);
		u_bus_masters.go(1, 32'h100); chk(ibv, 6'h04);
		$display("conflict test done");
	endtask
	task automatic tally_and_finish;
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		{ipl, lpl, ie, le, cx, ip, lp} = 9'h0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'h1;
		t_place;
		t_window;
		t_conflict;
		tally_and_finish;
	end
	initial
	begin
		repeat (2000) @(posedge ref_clk);
		fail_count++;
		tally_and_finish;
	end
endmodule
bind module_select_decode modsel_sva u_modsel_sva (.ref_clk(ref_clk), .rst_n(rst_n),
	.instr_mem_placement(instr_mem_placement), .ldst_mem_placement(ldst_mem_placement),
	.instr_mem_present(instr_mem_present), .ldst_mem_present(ldst_mem_present),
	.ib_valid(ib_valid), .ib_addr(ib_addr), .lb_valid(lb_valid), .lb_addr(lb_addr),
	.ib_sel_imem(ib_sel_imem), .ib_sel_lmem(ib_sel_lmem), .ib_sel_external(ib_sel_external),
	.ib_machine_check(ib_machine_check), .ib_transfer_error_ack(ib_transfer_error_ack),
	.lb_sel_ctrl(lb_sel_ctrl), .lb_sel_bridge(lb_sel_bridge), .ib_error_q_out(ib_error_q_out));
